// [design/load_adaptive_fullstep_ctrl.sv]
// Purpose: load-adaptive fullstep commutation control with AXI4-Lite registers
// Assumes: coil rise time supplied per fullstep by the chopper
// Notes on behaviour
// - fullsteps at target velocity, slow on overload
// - stall flag set on complete block
// - restart after release when stop disabled
// - stay stopped until status read, event flag
// - load value readable, up to 511
// - above minimum velocity chopper goes fullstep
// - off-time 8 to 15 acts as 8 in adaptive mode
// - below minimum velocity run microsteps
// - minimum velocity zero disables mode
// - never below minimum velocity while adaptive
// - quiet chopper disables adaptive mode
// - programmable measurement pulse width 0-1023
// - stall sensitivity 0-255, higher more sensitive
// - adaptive forces constant off-time slow decay
`timescale 1ns/1ps
module load_adaptive_fullstep_ctrl (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic [9:0] i_coil_time,
  input wire logic i_coil_strobe,
  output logic o_fullstep_mode,
  output logic o_const_off_slow,
  output logic [3:0] o_chopper_off_time,
  output logic [22:0] o_step_velocity,
  output logic o_stall
);
  // ==========================================================================
  // registers
  logic stop_on_stall_enable_q;
  logic quiet_mode_q;
  logic [22:0] adaptive_min_velocity_q;
  logic [22:0] ramp_target_velocity_q;
  logic [22:0] load_ctrl_lower_velocity_q;
  logic [5:0] chopper_configuration_q;
  logic [9:0] load_meas_pulse_width_q;
  logic [7:0] adaptive_stall_sensitivity_q;
  logic stall_q;
  logic stall_stop_event_q;
  logic [22:0] vel_q;
  logic [22:0] vel_d;
  adaptive_pkg::mode_t mode_q;
  adaptive_pkg::mode_t mode_d;
  logic fs_q;
  logic cos_q;
  logic [3:0] chopper_off_time_q;
  logic [22:0] outvel_q;
  logic stall_out_q;
  logic coil_s1_q;
  logic coil_s2_q;
  logic [9:0] ct_s1_q;
  logic [9:0] ct_s2_q;
  // bus state
  logic aw_held_q;
  logic [7:0] aw_addr_q;
  logic w_held_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic awready_q;
  logic wready_q;
  logic arready_q;

  load_meas_if lm ();

  load_meas u_meas (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .m(lm)
  );

  // ==========================================================================
  // byte-lane merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // ==========================================================================
  // write channel
  wire do_write = aw_held_q && w_held_q && !bvalid_q;
  wire w_ctrl = do_write && (aw_addr_q == adaptive_pkg::ADDR_CTRL);
  wire w_min = do_write && (aw_addr_q == adaptive_pkg::ADDR_MIN_VEL);
  wire w_tgt = do_write && (aw_addr_q == adaptive_pkg::ADDR_TARGET_VEL);
  wire w_low = do_write && (aw_addr_q == adaptive_pkg::ADDR_LOWER_VEL);
  wire w_chop = do_write && (aw_addr_q == adaptive_pkg::ADDR_CHOP);
  wire w_pulse = do_write && (aw_addr_q == adaptive_pkg::ADDR_PULSE);
  wire w_sens = do_write && (aw_addr_q == adaptive_pkg::ADDR_SENS);
  wire w_mapped = w_ctrl | w_min | w_tgt | w_low | w_chop | w_pulse | w_sens;
  wire [31:0] m_ctrl = merge({30'h0, quiet_mode_q, stop_on_stall_enable_q}, w_data_q, w_strb_q);
  wire [31:0] m_min = merge({9'h0, adaptive_min_velocity_q}, w_data_q, w_strb_q);
  wire [31:0] m_tgt = merge({9'h0, ramp_target_velocity_q}, w_data_q, w_strb_q);
  wire [31:0] m_low = merge({9'h0, load_ctrl_lower_velocity_q}, w_data_q, w_strb_q);
  wire [31:0] m_chop = merge({26'h0, chopper_configuration_q}, w_data_q, w_strb_q);
  wire [31:0] m_pulse = merge({22'h0, load_meas_pulse_width_q}, w_data_q, w_strb_q);
  wire [31:0] m_sens = merge({24'h0, adaptive_stall_sensitivity_q}, w_data_q, w_strb_q);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_held_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= adaptive_pkg::RESP_OKAY;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
    end else begin
      if (i_awvalid && !aw_held_q) begin
        aw_held_q <= 1'b1;
        awready_q <= 1'b0;
        aw_addr_q <= {i_awaddr[7:2], 2'b00};
      end
      if (i_wvalid && !w_held_q) begin
        w_held_q <= 1'b1;
        wready_q <= 1'b0;
        w_data_q <= i_wdata;
        w_strb_q <= i_wstrb;
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
        bvalid_q <= 1'b1;
        bresp_q <= w_mapped ? adaptive_pkg::RESP_OKAY : adaptive_pkg::RESP_SLVERR;
      end else if (bvalid_q && i_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      stop_on_stall_enable_q <= 1'b0;
      quiet_mode_q <= 1'b0;
      adaptive_min_velocity_q <= adaptive_pkg::VEL_ZERO;
      load_ctrl_lower_velocity_q <= adaptive_pkg::VEL_ZERO;
      chopper_configuration_q <= 6'h00;
      load_meas_pulse_width_q <= 10'h000;
      adaptive_stall_sensitivity_q <= 8'h00;
    end else begin
      if (w_ctrl) begin
        stop_on_stall_enable_q <= m_ctrl[adaptive_pkg::CTRL_STOP_BIT];
        quiet_mode_q <= m_ctrl[adaptive_pkg::CTRL_QUIET_BIT];
      end
      if (w_min) adaptive_min_velocity_q <= m_min[adaptive_pkg::VEL_W-1:0];
      if (w_low) load_ctrl_lower_velocity_q <= m_low[adaptive_pkg::VEL_W-1:0];
      if (w_chop) chopper_configuration_q <= m_chop[5:0];
      if (w_pulse) load_meas_pulse_width_q <= m_pulse[adaptive_pkg::PULSE_W-1:0];
      if (w_sens) adaptive_stall_sensitivity_q <= m_sens[adaptive_pkg::SENS_W-1:0];
    end
  end

  // ==========================================================================
  // read channel
  wire rd_take = i_arvalid && !rvalid_q;
  wire [7:0] ra = {i_araddr[7:2], 2'b00};
  wire rd_status = rd_take && (ra == adaptive_pkg::ADDR_STATUS);
  wire [31:0] status_word = {28'h0, fs_q, (mode_q == adaptive_pkg::MODE_ADAPT), stall_stop_event_q, stall_q};
  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case (ra)
      adaptive_pkg::ADDR_CTRL: rd_mux = {30'h0, quiet_mode_q, stop_on_stall_enable_q};
      adaptive_pkg::ADDR_MIN_VEL: rd_mux = {9'h0, adaptive_min_velocity_q};
      adaptive_pkg::ADDR_TARGET_VEL: rd_mux = {9'h0, ramp_target_velocity_q};
      adaptive_pkg::ADDR_LOWER_VEL: rd_mux = {9'h0, load_ctrl_lower_velocity_q};
      adaptive_pkg::ADDR_CHOP: rd_mux = {26'h0, chopper_configuration_q};
      adaptive_pkg::ADDR_PULSE: rd_mux = {22'h0, load_meas_pulse_width_q};
      adaptive_pkg::ADDR_SENS: rd_mux = {24'h0, adaptive_stall_sensitivity_q};
      adaptive_pkg::ADDR_STATUS: rd_mux = status_word;
      adaptive_pkg::ADDR_LOAD: rd_mux = {23'h0, lm.load_value};
      adaptive_pkg::ADDR_ACT_VEL: rd_mux = {9'h0, vel_q};
      default: begin
        rd_mux = adaptive_pkg::UNMAPPED_READ;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= adaptive_pkg::RESP_OKAY;
      arready_q <= 1'b1;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      arready_q <= 1'b0;
      rdata_q <= rd_mux;
      rresp_q <= rd_ok ? adaptive_pkg::RESP_OKAY : adaptive_pkg::RESP_SLVERR;
    end else if (rvalid_q && i_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ==========================================================================
  // coil measurement input synchroniser
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      coil_s1_q <= 1'b0;
      coil_s2_q <= 1'b0;
      ct_s1_q <= 10'h000;
      ct_s2_q <= 10'h000;
    end else begin
      coil_s1_q <= i_coil_strobe;
      coil_s2_q <= coil_s1_q;
      ct_s1_q <= i_coil_time;
      ct_s2_q <= ct_s1_q;
    end
  end

  // ==========================================================================
  // mode selection and velocity control
  wire mode_en = (adaptive_min_velocity_q != adaptive_pkg::VEL_ZERO) && !quiet_mode_q;
  wire above_min = ramp_target_velocity_q > adaptive_min_velocity_q;
  wire stall_now = (mode_q == adaptive_pkg::MODE_ADAPT) && lm.blocked && (vel_q <= adaptive_min_velocity_q);
  wire stop_hold = stall_stop_event_q;
  wire [3:0] chopper_off_time_raw = chopper_configuration_q[adaptive_pkg::CHOP_CHOPPER_OFF_TIME_LSB +: adaptive_pkg::CHOP_CHOPPER_OFF_TIME_W];

  assign lm.active = (mode_q == adaptive_pkg::MODE_ADAPT);
  assign lm.pulse_width = load_meas_pulse_width_q;
  assign lm.sensitivity = adaptive_stall_sensitivity_q;
  assign lm.coil_time = ct_s2_q;
  assign lm.coil_strobe = coil_s2_q;

  always_comb begin
    mode_d = adaptive_pkg::MODE_MICRO;
    vel_d = ramp_target_velocity_q;
    case (mode_q)
      adaptive_pkg::MODE_MICRO: begin
        vel_d = ramp_target_velocity_q;
        if (mode_en && above_min && !stop_hold) mode_d = adaptive_pkg::MODE_ADAPT;
        else if (stop_hold) mode_d = adaptive_pkg::MODE_STALL;
      end
      adaptive_pkg::MODE_ADAPT: begin
        mode_d = adaptive_pkg::MODE_ADAPT;
        if (lm.overload && vel_q > adaptive_min_velocity_q) begin
          vel_d = vel_q - adaptive_pkg::VEL_STEP;
        end else if (!lm.overload && vel_q < ramp_target_velocity_q) begin
          vel_d = vel_q + adaptive_pkg::VEL_STEP;
        end else if (vel_q > ramp_target_velocity_q) begin
          vel_d = ramp_target_velocity_q;
        end else begin
          vel_d = vel_q;
        end
        if (vel_d < adaptive_min_velocity_q) vel_d = adaptive_min_velocity_q;
        if (stall_now && stop_on_stall_enable_q) begin
          mode_d = adaptive_pkg::MODE_STALL;
          vel_d = adaptive_pkg::VEL_ZERO;
        end else if (!mode_en || !above_min) begin
          mode_d = adaptive_pkg::MODE_MICRO;
          vel_d = ramp_target_velocity_q;
        end
      end
      adaptive_pkg::MODE_STALL: begin
        vel_d = adaptive_pkg::VEL_ZERO;
        mode_d = stop_hold ? adaptive_pkg::MODE_STALL : adaptive_pkg::MODE_MICRO;
      end
      default: begin
        mode_d = adaptive_pkg::MODE_MICRO;
        vel_d = adaptive_pkg::VEL_ZERO;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ramp_target_velocity_q <= adaptive_pkg::VEL_ZERO;
      stall_q <= 1'b0;
      stall_stop_event_q <= 1'b0;
      mode_q <= adaptive_pkg::MODE_MICRO;
      vel_q <= adaptive_pkg::VEL_ZERO;
    end else begin
      mode_q <= mode_d;
      vel_q <= vel_d;
      if (stall_now && stop_on_stall_enable_q) begin
        ramp_target_velocity_q <= adaptive_pkg::VEL_ZERO;
      end else if (w_tgt && !stop_hold) begin
        ramp_target_velocity_q <= m_tgt[adaptive_pkg::VEL_W-1:0];
      end
      // set wins over the status-read clear
      if (stall_now) stall_q <= 1'b1;
      else if (rd_status) stall_q <= 1'b0;
      if (stall_now && stop_on_stall_enable_q) stall_stop_event_q <= 1'b1;
      else if (rd_status) stall_stop_event_q <= 1'b0;
    end
  end

  // ==========================================================================
  // chopper outputs
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      fs_q <= 1'b0;
      cos_q <= 1'b0;
      chopper_off_time_q <= 4'h0;
      outvel_q <= adaptive_pkg::VEL_ZERO;
      stall_out_q <= 1'b0;
    end else begin
      fs_q <= (mode_d == adaptive_pkg::MODE_ADAPT);
      cos_q <= (mode_d == adaptive_pkg::MODE_ADAPT);
      chopper_off_time_q <= ((mode_d == adaptive_pkg::MODE_ADAPT) && chopper_off_time_raw > adaptive_pkg::CHOPPER_OFF_TIME_CAP) ?
                adaptive_pkg::CHOPPER_OFF_TIME_CAP : chopper_off_time_raw;
      outvel_q <= vel_d;
      stall_out_q <= stall_now | stall_q;
    end
  end

  assign o_fullstep_mode = fs_q;
  assign o_const_off_slow = cos_q;
  assign o_chopper_off_time = chopper_off_time_q;
  assign o_step_velocity = outvel_q;
  assign o_stall = stall_out_q;
  assign o_awready = awready_q;
  assign o_wready = wready_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign o_arready = arready_q;
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;
endmodule : load_adaptive_fullstep_ctrl

// [design/load_meas.sv]
// Purpose: load measurement and stall judgement from coil rise times
// Assumes: coil_time is cycles for the coil current to reach target
// Notes: load value 0 when time well inside the reference pulse
`timescale 1ns/1ps
module load_meas (
  input wire logic i_clk,
  input wire logic i_nrst,
  load_meas_if.meas m
);
  logic [8:0] load_q;
  logic [8:0] load_d;
  logic over_q;
  logic block_q;
  logic [10:0] excess;
  logic [8:0] thresh;

  // ==========================================================================
  // load figure: amount by which the coil time exceeds the reference
  // borrow in bit 10 means the coil beat the reference: no load
  assign excess = {1'b0, m.coil_time} - {1'b0, m.pulse_width};
  assign load_d = excess[10] ? 9'h000 :
                  (excess[9] ? adaptive_pkg::LOAD_ABS_MAX : excess[8:0]);
  assign thresh = adaptive_pkg::LOAD_ABS_MAX - {1'b0, m.sensitivity};

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      load_q <= 9'h000;
      over_q <= 1'b0;
      block_q <= 1'b0;
    end else if (m.coil_strobe && m.active) begin
      load_q <= load_d;
      over_q <= (load_d != 9'h000);
      block_q <= (load_d >= thresh);
    end else if (!m.active) begin
      over_q <= 1'b0;
      block_q <= 1'b0;
    end
  end

  assign m.load_value = load_q;
  assign m.overload = over_q;
  assign m.blocked = block_q;
endmodule : load_meas

// [shared/adaptive_pkg.sv]
// Purpose: constants and types for the load-adaptive fullstep controller
// Assumes: 32-bit AXI4-Lite register access, 40 MHz clock
// Notes: offsets are byte addresses
package adaptive_pkg;
  // ==========================================================================
  // register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MIN_VEL = 8'h04;
  localparam logic [7:0] ADDR_TARGET_VEL = 8'h08;
  localparam logic [7:0] ADDR_LOWER_VEL = 8'h0C;
  localparam logic [7:0] ADDR_CHOP = 8'h10;
  localparam logic [7:0] ADDR_PULSE = 8'h14;
  localparam logic [7:0] ADDR_SENS = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_LOAD = 8'h20;
  localparam logic [7:0] ADDR_ACT_VEL = 8'h24;
  // ==========================================================================
  // field layout
  localparam int CTRL_STOP_BIT = 0;
  localparam int CTRL_QUIET_BIT = 1;
  localparam int CHOP_CHOPPER_OFF_TIME_LSB = 0;
  localparam int CHOP_CHOPPER_OFF_TIME_W = 4;
  localparam int CHOP_FS_BIT = 4;
  localparam int CHOP_CHM_BIT = 5;
  localparam int ST_STALL_BIT = 0;
  localparam int ST_EVENT_BIT = 1;
  localparam int ST_ADAPT_BIT = 2;
  localparam int ST_FULL_BIT = 3;
  localparam int VEL_W = 23;
  localparam int PULSE_W = 10;
  localparam int SENS_W = 8;
  localparam int LOAD_W = 9;
  // ==========================================================================
  // values
  localparam logic [3:0] CHOPPER_OFF_TIME_CAP = 4'h8;
  localparam logic [VEL_W-1:0] VEL_ZERO = 23'h000000;
  localparam logic [LOAD_W-1:0] LOAD_NORMAL_MAX = 9'h0FF;
  localparam logic [LOAD_W-1:0] LOAD_ABS_MAX = 9'h1FF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
  localparam logic [VEL_W-1:0] VEL_STEP = 23'h000001;
  typedef enum logic [1:0] {
    MODE_MICRO = 2'b00,
    MODE_ADAPT = 2'b01,
    MODE_STALL = 2'b10
  } mode_t;
endpackage : adaptive_pkg

// [shared/load_meas_if.sv]
// Purpose: carrier between controller and load measurement unit
// Assumes: single clock domain
// Notes: none
`timescale 1ns/1ps
interface load_meas_if;
  logic active;
  logic [9:0] pulse_width;
  logic [7:0] sensitivity;
  logic [9:0] coil_time;
  logic coil_strobe;
  logic overload;
  logic blocked;
  logic [8:0] load_value;
  modport ctrl (output active, output pulse_width, output sensitivity, output coil_time, output coil_strobe,
    input overload, input blocked, input load_value);
  modport meas (input active, input pulse_width, input sensitivity, input coil_time, input coil_strobe,
    output overload, output blocked, output load_value);
endinterface : load_meas_if

// [tb/load_adaptive_fullstep_ctrl_properties.sv]
// Purpose: port-level properties of the adaptive controller
// Assumes: one clock, async active-low reset
// Notes: mode settings shadowed from completed writes
`timescale 1ns/1ps
module load_adaptive_fullstep_ctrl_properties (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_rvalid,
  input wire logic o_fullstep_mode,
  input wire logic o_const_off_slow,
  input wire logic [3:0] o_chopper_off_time,
  input wire logic o_stall
);
  // ==========================================================================
  // shadow of minimum velocity and quiet bit
  logic [7:0] awa_q;
  logic [31:0] wd_q;
  logic [22:0] min_q;
  logic quiet_q;
  logic idle;
  logic wr_ok;
  assign idle = o_awready && !o_bvalid;
  assign wr_ok = o_bvalid && i_bready && o_bresp == adaptive_pkg::RESP_OKAY;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      awa_q <= 8'h00;
      wd_q <= 32'h00000000;
      min_q <= 23'h000000;
      quiet_q <= 1'b0;
    end else begin
      if (i_awvalid && o_awready) awa_q <= i_awaddr;
      if (i_wvalid && o_wready) wd_q <= i_wdata;
      if (wr_ok && awa_q == adaptive_pkg::ADDR_MIN_VEL) min_q <= wd_q[22:0];
      if (wr_ok && awa_q == adaptive_pkg::ADDR_CTRL) quiet_q <= wd_q[adaptive_pkg::CTRL_QUIET_BIT];
    end
  end
  // ==========================================================================
  // properties
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid) else $error("read answer late");
  a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:2] o_bvalid)
    else $error("write answer late");
  a_aw_busy: assert property (i_awvalid && o_awready |=> !o_awready) else $error("awready stayed high");
  a_err_data: assert property (o_rvalid && o_rresp == adaptive_pkg::RESP_SLVERR |-> o_rdata == 32'h00000000)
    else $error("error read data not zero");
  a_zero_min_off: assert property ((min_q == 23'h000000 && idle) [*3] |-> !o_fullstep_mode)
    else $error("adaptive with zero minimum");
  a_quiet_off: assert property ((quiet_q && idle) [*3] |-> !o_fullstep_mode)
    else $error("adaptive with quiet chopper");
  a_off_cap: assert property (o_fullstep_mode [*2] |-> o_chopper_off_time <= 4'h8)
    else $error("off time above cap");
  a_const_off: assert property (o_fullstep_mode [*2] |-> o_const_off_slow)
    else $error("slow decay missing");
  a_stall_cause: assert property ($rose(o_stall) |-> $past(o_fullstep_mode))
    else $error("stall outside adaptive");
  c_adapt: cover property ($rose(o_fullstep_mode));
  c_stall: cover property ($rose(o_stall));
  c_err: cover property (o_rvalid && o_rresp == adaptive_pkg::RESP_SLVERR);
endmodule : load_adaptive_fullstep_ctrl_properties

bind load_adaptive_fullstep_ctrl load_adaptive_fullstep_ctrl_properties u_props (.i_clk, .i_nrst, .i_awaddr,
  .i_awvalid, .o_awready, .i_wdata, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_arvalid,
  .o_arready, .o_rdata, .o_rresp, .o_rvalid, .o_fullstep_mode, .o_const_off_slow, .o_chopper_off_time, .o_stall);

// [tb/load_adaptive_fullstep_ctrl_tb.sv]
// Purpose: self-checking bench for the adaptive controller
// Assumes: AXI4-Lite master driven here, coil time driven here
// Notes: read results checked from a queue by a monitor
`timescale 1ns/1ps
module load_adaptive_fullstep_ctrl_tb;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} exp_t;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  logic i_coil_strobe = 1'b0;
  logic [31:0] i_wdata = 32'h00000000;
  logic [3:0] i_wstrb = 4'hF;
  logic [9:0] i_coil_time = 10'h000;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_fullstep_mode, o_const_off_slow, o_stall;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata;
  logic [3:0] o_chopper_off_time;
  logic [22:0] o_step_velocity;
  exp_t rq[$];
  logic [1:0] bq[$];
  exp_t e;
  logic [1:0] b;
  logic [31:0] v;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;

  load_adaptive_fullstep_ctrl dut (.i_clk, .i_nrst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
    .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
    .o_rresp, .o_rvalid, .i_rready, .i_coil_time, .i_coil_strobe, .o_fullstep_mode, .o_const_off_slow,
    .o_chopper_off_time, .o_step_velocity, .o_stall);

  initial begin
    forever #12.5 i_clk = ~i_clk;
  end

  // ==========================================================================
  // compare, verdict
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    checks++;
    if ((got & m) !== (exp & m)) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic finish_test;
    $display("checks=%0d errors=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end

  // monitor: oldest note against each answer
  always @(posedge i_clk) begin
    if (o_rvalid === 1'b1 && i_rready) begin
      e = rq.pop_front();
      cmp(o_rdata, e.d, e.m);
      cmp({30'h0, o_rresp}, {30'h0, e.r}, 32'h3);
    end
    if (o_bvalid === 1'b1 && i_bready) begin
      b = bq.pop_front();
      if (b !== 2'h3) cmp({30'h0, o_bresp}, {30'h0, b}, 32'h3);
    end
  end

  // ==========================================================================
  // bus master
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge i_clk);
    bq.push_back(r);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
    end while (o_bvalid !== 1'b1);
    i_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
    @(posedge i_clk);
    rq.push_back('{d, m, r});
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (o_arready) i_arvalid <= 1'b0;
    end while (o_rvalid !== 1'b1);
    i_rready <= 1'b0;
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : settle

  // ==========================================================================
  // tests
  initial begin
    v = $urandom(32'h8E63);
    repeat (5) @(posedge i_clk);
    i_nrst <= 1'b1;
    rd(adaptive_pkg::ADDR_STATUS, 32'h0, 32'hF, 2'h0);
    v = $urandom();
    wr(adaptive_pkg::ADDR_PULSE, v, 2'h0);
    rd(adaptive_pkg::ADDR_PULSE, {22'h0, v[9:0]}, 32'hFFFFFFFF, 2'h0);
    wr(adaptive_pkg::ADDR_SENS, v, 2'h0);
    rd(adaptive_pkg::ADDR_SENS, {24'h0, v[7:0]}, 32'hFFFFFFFF, 2'h0);
    rd(8'h30, 32'h0, 32'hFFFFFFFF, 2'h2);
    wr(adaptive_pkg::ADDR_LOAD, 32'h1, 2'h2);
    $display("register test done");
    wr(adaptive_pkg::ADDR_PULSE, 32'd100, 2'h0);
    wr(adaptive_pkg::ADDR_SENS, 32'd200, 2'h0);
    wr(adaptive_pkg::ADDR_CHOP, 32'h3D, 2'h0);
    wr(adaptive_pkg::ADDR_TARGET_VEL, 32'd200, 2'h0);
    settle(20);
    cmp(o_fullstep_mode, 32'h0, 32'h1);
    cmp(o_chopper_off_time, 32'hD, 32'hF);
    wr(adaptive_pkg::ADDR_MIN_VEL, 32'd50, 2'h0);
    wr(adaptive_pkg::ADDR_LOWER_VEL, 32'd60, 2'h0);
    rd(adaptive_pkg::ADDR_LOWER_VEL, 32'd60, 32'hFFFFFFFF, 2'h0);
    settle(300);
    cmp(o_fullstep_mode, 32'h1, 32'h1);
    cmp(o_const_off_slow, 32'h1, 32'h1);
    rd(adaptive_pkg::ADDR_STATUS, 32'hC, 32'hC, 2'h0);
    rd(adaptive_pkg::ADDR_ACT_VEL, 32'd200, 32'hFFFFFFFF, 2'h0);
    for (int t = 0; t < 16; t++) begin
      wr(adaptive_pkg::ADDR_CHOP, 32'h30 | t, 2'h0);
      settle(3);
      cmp(o_chopper_off_time, (t > 8) ? 32'h8 : t, 32'hF);
    end
    wr(adaptive_pkg::ADDR_CTRL, 32'h2, 2'h0);
    settle(5);
    cmp(o_fullstep_mode, 32'h0, 32'h1);
    wr(adaptive_pkg::ADDR_CTRL, 32'h0, 2'h0);
    wr(adaptive_pkg::ADDR_TARGET_VEL, 32'd30, 2'h0);
    settle(20);
    cmp(o_fullstep_mode, 32'h0, 32'h1);
    wr(adaptive_pkg::ADDR_TARGET_VEL, 32'd200, 2'h0);
    settle(300);
    $display("mode test done");
    @(posedge i_clk);
    i_coil_time <= 10'd150;
    i_coil_strobe <= 1'b1;
    settle(300);
    rd(adaptive_pkg::ADDR_LOAD, 32'd50, 32'hFFFFFFFF, 2'h0);
    rd(adaptive_pkg::ADDR_ACT_VEL, 32'd50, 32'hFFFFFFFF, 2'h0);
    cmp(o_fullstep_mode, 32'h1, 32'h1);
    i_coil_time <= 10'h3FF;
    settle(20);
    rd(adaptive_pkg::ADDR_LOAD, 32'd511, 32'hFFFFFFFF, 2'h0);
    rd(adaptive_pkg::ADDR_STATUS, 32'h1, 32'h1, 2'h0);
    rd(adaptive_pkg::ADDR_ACT_VEL, 32'd50, 32'hFFFFFFFF, 2'h0);
    i_coil_time <= 10'd50;
    settle(300);
    rd(adaptive_pkg::ADDR_ACT_VEL, 32'd200, 32'hFFFFFFFF, 2'h0);
    rd(adaptive_pkg::ADDR_STATUS, 32'h1, 32'h3, 2'h0);
    rd(adaptive_pkg::ADDR_STATUS, 32'h0, 32'h3, 2'h0);
    $display("overload test done");
    wr(adaptive_pkg::ADDR_CTRL, 32'h1, 2'h0);
    i_coil_time <= 10'h3FF;
    settle(300);
    cmp(o_stall, 32'h1, 32'h1);
    rd(adaptive_pkg::ADDR_TARGET_VEL, 32'h0, 32'hFFFFFFFF, 2'h0);
    cmp(o_step_velocity, 32'h0, 32'h7FFFFF);
    wr(adaptive_pkg::ADDR_TARGET_VEL, 32'd300, 2'h0);
    rd(adaptive_pkg::ADDR_TARGET_VEL, 32'h0, 32'hFFFFFFFF, 2'h0);
    i_coil_time <= 10'd50;
    settle(50);
    rd(adaptive_pkg::ADDR_STATUS, 32'h2, 32'h2, 2'h0);
    rd(adaptive_pkg::ADDR_STATUS, 32'h0, 32'h2, 2'h0);
    wr(adaptive_pkg::ADDR_TARGET_VEL, 32'd300, 2'h0);
    rd(adaptive_pkg::ADDR_TARGET_VEL, 32'd300, 32'hFFFFFFFF, 2'h0);
    settle(400);
    cmp(o_fullstep_mode, 32'h1, 32'h1);
    rd(adaptive_pkg::ADDR_ACT_VEL, 32'd300, 32'hFFFFFFFF, 2'h0);
    cmp(o_step_velocity, 32'd300, 32'h7FFFFF);
    $display("stop test done");
    finish_test();
  end
endmodule : load_adaptive_fullstep_ctrl_tb
